// [wss_status_regs.sv]
// Wake source, strap and timer status registers answering serial frames
`timescale 1ns/1ps
module wss_status_regs (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     request_valid,
  input  wire logic [15:0]              request_word,
  input  wire wss_pkg::wss_summary_type summary_flags,
  input  wire wss_pkg::wss_strap_type   strap_pins,
  input  wire logic                     low_power_off_mode,
  input  wire wss_pkg::wss_wake_type    wake_events,
  input  wire wss_pkg::wss_timer_type   timer_status,
  output logic [15:0]                   response_word,
  output logic                          response_valid,
  output logic                          timer_interrupt_flag
);

  // State of the register bank, apart from the wake and timer sticky flags
  typedef struct packed {
    logic [15:0]           response;
    logic                  response_valid;
    wss_pkg::wss_strap_type straps;
    logic                  strap_sample_pending;
    logic                  off_mode_seen;
  } wss_state_type;

  wss_state_type state_q;
  wss_state_type state_d;

  logic          read_strap;
  logic          read_wake;
  logic          read_timer;
  logic [7:0]    wake_flags_q;
  logic [7:0]    wake_set;
  logic [0:0]    timer_flag_q;
  logic [0:0]    timer_flag_set;
  logic          clear_wake;
  logic          clear_timer;
  logic [7:0]    strap_byte;
  logic [7:0]    timer_byte;

  // Decode of the request frame
  always_comb begin
    read_strap = request_valid
               && (request_word == wss_pkg::REQ_STRAP_READ); // RL3
    read_wake  = request_valid
               && (request_word == wss_pkg::REQ_WAKE_READ); // RL4
    read_timer = request_valid
               && (request_word == wss_pkg::REQ_TIMER_READ);
  end

  // Wake events enter the sticky flags in response bit order
  assign wake_set = wake_events; // RL13 RL14 RL16

  // The flags are read in the same cycle as the clear is applied
  assign clear_wake = read_wake; // RL15 RL17

  // Wake source flags, cleared on power-on reset and on read
  wss_sticky_flags #(
    .WIDTH (wss_pkg::WAKE_WIDTH)
  ) u_wake_flags (
    .clk     (clk),
    .rst_b   (rst_b),
    .set     (wake_set),
    .clear   (clear_wake),
    .flags_q (wake_flags_q)
  );

  // Timer interrupt only produced in function 1 on after-run match
  always_comb begin
    timer_flag_set[0] = timer_status.after_run_reached
      && (timer_status.timer_function == wss_pkg::TIMER_FUNCTION_1); // RL1 RL2
  end

  // Timer flag clears on read of the timer register
  assign clear_timer = read_timer; // RL2 RL17

  wss_sticky_flags #(
    .WIDTH (1)
  ) u_timer_flag (
    .clk     (clk),
    .rst_b   (rst_b),
    .set     (timer_flag_set),
    .clear   (clear_timer),
    .flags_q (timer_flag_q)
  );

  // Low byte of the strap register from the captured straps
  always_comb begin
    strap_byte    = 8'h00;
    strap_byte[7] = state_q.straps.preregulator_topology_flag; // RL6
    strap_byte[6] = wss_pkg::STRAP_RESERVED; // RL11
    strap_byte[5] = state_q.straps.external_pass_transistor_flag; // RL7
    strap_byte[4] = state_q.straps.analog_rail_voltage_strap; // RL8
    strap_byte[3] = state_q.straps.aux_rail_voltage_strap; // RL8
    strap_byte[2] = wss_pkg::STRAP_FIXED_ONE; // RL11
    strap_byte[1] = state_q.straps.deep_failsafe_strap; // RL9
    strap_byte[0] = state_q.straps.debug_strap; // RL10
  end

  // Low byte of the timer register: control echo plus status
  always_comb begin
    timer_byte    = 8'h00;
    timer_byte[7:5] = timer_status.timer_function;
    timer_byte[4] = timer_status.counter_select;
    timer_byte[3] = timer_status.timer_running_flag;
    timer_byte[2] = timer_status.resolution_mode;
    timer_byte[1] = timer_status.counter_enable;
    timer_byte[0] = timer_flag_q[0]; // RL1
  end

  // Next state: strap capture and response assembly
  always_comb begin
    state_d                = state_q;
    state_d.response_valid = 1'b0;
    state_d.off_mode_seen  = low_power_off_mode;

    // Straps are caught once after reset release and on leaving off mode
    if (state_q.strap_sample_pending) begin
      state_d.straps               = strap_pins; // RL12
      state_d.strap_sample_pending = 1'b0;
    end
    if (state_q.off_mode_seen && !low_power_off_mode) begin
      state_d.strap_sample_pending = 1'b1; // RL12
    end

    // Every answer carries the summary flags in its upper byte
    if (request_valid) begin
      state_d.response_valid = 1'b1;
      state_d.response       = {summary_flags, 8'h00}; // RL5
      if (read_strap) begin
        state_d.response[7:0] = strap_byte;
      end else if (read_wake) begin
        state_d.response[7:0] = wake_flags_q; // RL17
      end else if (read_timer) begin
        state_d.response[7:0] = timer_byte;
      end else begin
        state_d.response[7:0] = 8'h00;
      end
    end
  end

  // State register; straps are sampled on the first edge after reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q.response             <= wss_pkg::RESPONSE_RESET;
      state_q.response_valid       <= 1'b0;
      state_q.straps               <= '0;
      state_q.strap_sample_pending <= 1'b1; // RL12
      state_q.off_mode_seen        <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flip-flops
  assign response_word        = state_q.response;
  assign response_valid       = state_q.response_valid;
  assign timer_interrupt_flag = timer_flag_q[0];

endmodule : wss_status_regs

// [wss_pkg.sv]
// Package of constants and carrier types for the wake and strap status block
// Overview of operation
// RL1 - Timer interrupt flag sets at after-run match
// RL2 - Only in function 1; clears on reset/read
// RL3 - Host reads strap register with bit 12
// RL4 - Host reads wake register with bits 12,9
// RL5 - Response bits 15:8 carry eight summary flags
// RL6 - Bit 7 reports preregulator topology
// RL7 - Bit 5 reports analog rail pass device
// RL8 - Analog strap 1=5.0 V; aux inverted
// RL9 - Bit 1 reports deep fail-safe strap
// RL10 - Bit 0 reports debug strap
// RL11 - Bit 2 reads one; bit 6 reserved
// RL12 - Straps sampled at reset and leaving off
// RL13 - Wake bits 7..3 flag lines 5,4,3,2,0
// RL14 - Wake bit 2 flags automatic wake
// RL15 - Wake flags clear on reset and read
// RL16 - Wake bit 1 timer, bit 0 transceiver
// RL17 - Clear only after capture into response
package wss_pkg;

  // Request frames that select a register
  localparam logic [15:0] REQ_STRAP_READ = 16'h1000;
  localparam logic [15:0] REQ_WAKE_READ  = 16'h1200;
  localparam logic [15:0] REQ_TIMER_READ = 16'h0C00;

  // Timer function codes
  localparam logic [2:0]  TIMER_FUNCTION_1 = 3'h0;

  // Fixed and reserved bits of the strap response
  localparam logic        STRAP_FIXED_ONE = 1'b1;
  localparam logic        STRAP_RESERVED  = 1'b0;

  // Reset values and the wake flag width
  localparam logic [15:0] RESPONSE_RESET  = 16'h0000;
  localparam logic [7:0]  WAKE_RESET      = 8'h00;
  localparam int          WAKE_WIDTH      = 8;

  // Global summary flags, response bits 15 down to 8
  typedef struct packed {
    logic serial_summary_flag;
    logic wake_summary_flag;
    logic can_summary_flag;
    logic lin_summary_flag;
    logic io_summary_flag;
    logic preregulator_summary_flag;
    logic core_regulator_summary_flag;
    logic other_regulators_summary_flag;
  } wss_summary_type;

  // Configuration pins as presented on the strap inputs
  typedef struct packed {
    logic preregulator_topology_flag;
    logic external_pass_transistor_flag;
    logic analog_rail_voltage_strap;
    logic aux_rail_voltage_strap;
    logic deep_failsafe_strap;
    logic debug_strap;
  } wss_strap_type;

  // Wake events, one-cycle pulses, in response bit order 7..0
  typedef struct packed {
    logic line5_wake_flag;
    logic line4_wake_flag;
    logic line3_wake_flag;
    logic line2_wake_flag;
    logic line0_wake_flag;
    logic automatic_wake_flag;
    logic timer_wake_flag;
    logic transceiver_wake_flag;
  } wss_wake_type;

  // Timer control fields and status from the timer block
  typedef struct packed {
    logic [2:0] timer_function;
    logic       counter_select;
    logic       resolution_mode;
    logic       counter_enable;
    logic       timer_running_flag;
    logic       after_run_reached;
  } wss_timer_type;

endpackage : wss_pkg

// [wss_sticky_flags.sv]
// Sticky event flags with a common clear; set wins over clear
`timescale 1ns/1ps
module wss_sticky_flags #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic             clear,
  output logic      [WIDTH-1:0] flags_q
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } wss_sticky_state_type;

  wss_sticky_state_type state_q;
  wss_sticky_state_type state_d;

  // A clear in the same cycle as a set keeps the new event
  always_comb begin
    state_d       = state_q;
    state_d.flags = (state_q.flags & ~{WIDTH{clear}}) | set;
  end

  // Flags start cleared at power-on reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flags_q = state_q.flags;

endmodule : wss_sticky_flags

// [wss_status_props.sv]
// Checker of answer timing, summary byte and status flag behaviour
`timescale 1ns/1ps
module wss_status_props (
  input wire logic                     clk,
  input wire logic                     rst_b,
  input wire logic                     request_valid,
  input wire logic [15:0]              request_word,
  input wire wss_pkg::wss_summary_type summary_flags,
  input wire wss_pkg::wss_strap_type   strap_pins,
  input wire logic                     low_power_off_mode,
  input wire wss_pkg::wss_wake_type    wake_events,
  input wire wss_pkg::wss_timer_type   timer_status,
  input wire logic [15:0]              response_word,
  input wire logic                     response_valid,
  input wire logic                     timer_interrupt_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Decoded requests and the timer interrupt cause
  wire rd_s = request_valid && request_word == wss_pkg::REQ_STRAP_READ;
  wire rd_w = request_valid && request_word == wss_pkg::REQ_WAKE_READ;
  wire rd_t = request_valid && request_word == wss_pkg::REQ_TIMER_READ;
  wire t_set = timer_status.after_run_reached &&
    timer_status.timer_function == wss_pkg::TIMER_FUNCTION_1;
  sequence quiet_read;
    rd_w && wake_events == 8'h00;
  endsequence
  sequence quiet_gap;
    !request_valid && wake_events == 8'h00;
  endsequence
  sequence leave_off;
    $fell(low_power_off_mode) ##1
      (!low_power_off_mode && $stable(strap_pins))[*3] ##0 rd_s;
  endsequence
  a_answer_next: assert property (request_valid |=> response_valid)
    else $error("no answer after a request");
  a_answer_caused: assert property (response_valid |-> $past(request_valid))
    else $error("answer without a request");
  a_summary_byte: assert property (request_valid |=>
    response_word[15:8] == $past(summary_flags))
    else $error("summary byte differs from the flags");
  a_strap_fixed: assert property (rd_s |=>
    response_word[2] && !response_word[6])
    else $error("fixed strap bits wrong");
  a_strap_refresh: assert property (leave_off |=>
    response_word[7:0] == {$past(strap_pins[5]), 1'b0, $past(strap_pins[4:2]),
    1'b1, $past(strap_pins[1:0])})
    else $error("straps not refreshed after off mode");
  a_timer_int_set: assert property (t_set |=> timer_interrupt_flag)
    else $error("timer interrupt flag not set");
  a_timer_int_cause: assert property ($rose(timer_interrupt_flag) |->
    $past(t_set))
    else $error("timer interrupt flag set without cause");
  a_timer_int_clear: assert property (rd_t && !t_set |=>
    !timer_interrupt_flag)
    else $error("timer interrupt flag not cleared by a read");
  a_wake_read_clears: assert property (quiet_read ##1 quiet_gap
    ##1 quiet_read |=> response_word[7:0] == 8'h00)
    else $error("wake flags not cleared by a read");
endmodule : wss_status_props

// [wss_host_model.sv]
// Host model issuing request frames at the falling clock edge
`timescale 1ns/1ps
module wss_host_model (
  input  wire logic clk,
  output logic        request_valid,
  output logic [15:0] request_word
);
  initial {request_valid, request_word} = 17'h0_0000;
  // One frame held for one cycle; the released word is scrambled
  task automatic send(input logic [15:0] w);
    @(negedge clk);
    request_valid <= 1'b1;
    request_word  <= w;
    @(negedge clk);
    request_valid <= 1'b0;
    request_word  <= ~w;
  endtask : send
endmodule : wss_host_model

// [testbench.sv]
// Bench reading strap, wake and timer status through request frames
`timescale 1ns/1ps
module testbench;
  wss_pkg::wss_summary_type sum = 8'hC3;
  wss_pkg::wss_strap_type   strap = 6'h2D;
  wss_pkg::wss_wake_type    wake = 8'h00;
  wss_pkg::wss_timer_type   tim = 8'h00;
  logic [15:0]              rw;
  logic [15:0]              resp;
  logic                     clk = 1'b0;
  logic                     rst_b = 1'b0;
  logic                     off_mode = 1'b0;
  logic                     rv, resp_v, tif;
  int                       num_errors = 0;
  int                       checks_done = 0;
  always #25 clk = ~clk;
  wss_host_model host_u (.clk(clk), .request_valid(rv), .request_word(rw));
  wss_status_regs dut_u (.clk(clk), .rst_b(rst_b), .request_valid(rv),
    .request_word(rw), .summary_flags(sum), .strap_pins(strap),
    .low_power_off_mode(off_mode), .wake_events(wake), .timer_status(tim),
    .response_word(resp), .response_valid(resp_v),
    .timer_interrupt_flag(tif));
  // Send one frame and compare the answer while it stands
  task automatic rd(input logic [15:0] w, input logic [7:0] lo);
    host_u.send(w);
    checks_done++;
    if ({resp_v, resp} !== {1'b1, sum, lo}) begin
      num_errors++;
      $display("wrong value response to %h expected %h seen %h", w,
        {1'b1, sum, lo}, {resp_v, resp});
    end
  endtask : rd
  // Compare the sticky timer interrupt output
  task automatic chk(input logic exp, input logic seen);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value timer_interrupt_flag expected %b seen %b", exp,
        seen);
    end
  endtask : chk
  task automatic pulse(input logic [7:0] ev);
    @(negedge clk);
    wake = ev;
    @(negedge clk);
    wake = 8'h00;
  endtask : pulse
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  // Main sequence of register reads
  initial begin
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    rd(wss_pkg::REQ_STRAP_READ, 8'h9D);
    @(negedge clk);
    strap = 6'h12;
    rd(wss_pkg::REQ_STRAP_READ, 8'h9D);
    @(negedge clk);
    off_mode = 1'b1;
    @(negedge clk);
    off_mode = 1'b0;
    repeat (2) @(negedge clk);
    rd(wss_pkg::REQ_STRAP_READ, 8'h26);
    pulse(8'hA5);
    rd(wss_pkg::REQ_WAKE_READ, 8'hA5);
    fork
      rd(wss_pkg::REQ_WAKE_READ, 8'h00);
      pulse(8'h5A);
    join
    rd(wss_pkg::REQ_WAKE_READ, 8'h5A);
    rd(wss_pkg::REQ_WAKE_READ, 8'h00);
    pulse(8'h01);
    rd(16'h1201, 8'h00);
    rd(wss_pkg::REQ_WAKE_READ, 8'h01);
    @(negedge clk);
    tim = 8'h35;
    @(negedge clk);
    tim = 8'h34;
    chk(1'b0, tif);
    rd(wss_pkg::REQ_TIMER_READ, 8'h32);
    @(negedge clk);
    tim = 8'h15;
    @(negedge clk);
    tim = 8'h14;
    chk(1'b1, tif);
    rd(wss_pkg::REQ_TIMER_READ, 8'h13);
    chk(1'b0, tif);
    rd(wss_pkg::REQ_TIMER_READ, 8'h12);
    // Mid-run power-on reset drops pending flags and recaptures straps
    @(negedge clk);
    tim  = 8'h15;
    wake = 8'h81;
    @(negedge clk);
    tim  = 8'h14;
    wake = 8'h00;
    chk(1'b1, tif);
    rst_b = 1'b0;
    @(negedge clk);
    chk(1'b0, tif);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    rd(wss_pkg::REQ_WAKE_READ, 8'h00);
    rd(wss_pkg::REQ_STRAP_READ, 8'h26);
    close_out();
  end
  // Watchdog well beyond the roughly 53 cycles of the tests
  initial begin
    repeat (1000) @(posedge clk);
    num_errors++;
    close_out();
  end
endmodule : testbench
bind wss_status_regs wss_status_props chk_u (.clk(clk), .rst_b(rst_b),
  .request_valid(request_valid), .request_word(request_word),
  .summary_flags(summary_flags), .strap_pins(strap_pins),
  .low_power_off_mode(low_power_off_mode), .wake_events(wake_events),
  .timer_status(timer_status), .response_word(response_word),
  .response_valid(response_valid),
  .timer_interrupt_flag(timer_interrupt_flag));
